// [srf_filter_select.sv]
// Resonance filter selection with APB parameter registers
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "srf_params.svh"
module srf_filter_select #(
  parameter int              DATA_W     = 16,
  parameter int              PIPE_DEPTH = 6,
  parameter logic [7:0]      TUNE_COUNT = 8'h05
) (
  input  wire logic                   I_CLK,
  input  wire logic                   I_NRST,
  input  wire logic                   I_PSEL,
  input  wire logic                   I_PENABLE,
  input  wire logic                   I_PWRITE,
  input  wire logic [11:0]            I_PADDR,
  input  wire logic [31:0]            I_PWDATA,
  output logic                        O_PREADY,
  output logic [31:0]                 O_PRDATA,
  output logic                        O_PSLVERR,
  input  wire logic [DATA_W-1:0]      I_SAMPLE,
  input  wire logic                   I_SAMPLE_VALID,
  output logic [DATA_W-1:0]           O_SAMPLE,
  output logic                        O_SAMPLE_VALID,
  input  wire logic [4:0]             I_MOTOR_SHAFT_CODE,
  input  wire logic [15:0]            I_INERTIA_RATIO,
  input  wire logic                   I_POS_DONE,
  input  wire srf_pkg::srf_vs_est_s   I_VS1_EST,
  input  wire srf_pkg::srf_vs_est_s   I_VS2_EST,
  output srf_pkg::srf_filt_stat_s     O_FILT_STAT,
  output logic [15:0]                 O_SHAFT_HZ,
  output logic [4:0]                  O_SHAFT_CODE
);

  srf_pkg::srf_word_t cfg_r   [`SRF_NREG];
  srf_pkg::srf_word_t cfg_nxt [`SRF_NREG];
  logic [7:0]         tune_cnt_r [2];
  logic [7:0]         tune_cnt_nxt [2];
  logic [DATA_W-1:0]  pipe_r [PIPE_DEPTH];
  logic [PIPE_DEPTH-1:0] pipe_v_r;
  srf_pkg::srf_filt_stat_s stat_r;
  srf_pkg::srf_filt_stat_s stat_nxt;
  logic [15:0]        shaft_hz_r;
  logic [4:0]         shaft_code_r;
  logic               pready_r;
  logic [31:0]        prdata_r;
  logic               pslverr_r;

  // Low hex digit and second hex digit of a parameter word
  function automatic logic [3:0] dig0(input srf_pkg::srf_word_t w);
    return w[3:0];
  endfunction
  function automatic logic [3:0] dig1(input srf_pkg::srf_word_t w);
    return w[7:4];
  endfunction

  // Odd indices 1..9 hold notch frequencies
  function automatic logic is_notch_freq(input logic [4:0] idx);
    return idx[0] && (idx >= `SRF_IDX_N1_FREQ) &&
           (idx < `SRF_IDX_N5_SHAPE);
  endfunction

  function automatic srf_pkg::srf_word_t clamp_notch(
    input srf_pkg::srf_word_t w);
    if (w < `SRF_NOTCH_MIN_HZ) begin
      return `SRF_NOTCH_MIN_HZ;
    end else if (w > `SRF_NOTCH_MAX_HZ) begin
      return `SRF_NOTCH_MAX_HZ;
    end
    return w;
  endfunction

  function automatic logic est_in_range(input srf_pkg::srf_vs_est_s e);
    return e.valid &&
           (e.vib_freq >= `SRF_VS_EST_MIN) &&
           (e.vib_freq <= `SRF_VS_EST_MAX) &&
           (e.res_freq >= `SRF_VS_EST_MIN) &&
           (e.res_freq <= `SRF_VS_EST_MAX);
  endfunction

  // APB decode
  wire  [4:0] reg_idx    = I_PADDR[6:2];
  wire        addr_ok    = (I_PADDR[11:7] == 5'h00) &&
                           (I_PADDR[1:0] == 2'h0) &&
                           (reg_idx <= `SRF_IDX_STATUS);
  wire        setup      = I_PSEL && !I_PENABLE;
  wire        access     = I_PSEL && I_PENABLE && pready_r;
  wire        sw_wr      = access && I_PWRITE && addr_ok &&
                           (reg_idx != `SRF_IDX_STATUS);

  // Filter enables
  wire        gain_vs_ok = (dig0(cfg_r[`SRF_IDX_GAIN_MODE]) ==
                            `SRF_GAIN_AUTO2) ||
                           (dig0(cfg_r[`SRF_IDX_GAIN_MODE]) ==
                            `SRF_GAIN_MANUAL);
  wire  [3:0] vs1_mode   = dig0(cfg_r[`SRF_IDX_VS1_MODE]);
  wire  [3:0] vs2_mode   = dig1(cfg_r[`SRF_IDX_VS2_MODE]);
  wire        vs2_enable = dig0(cfg_r[`SRF_IDX_VS2_EN]) ==
                           `SRF_DIGIT_ON;
  wire        robust_on  = dig0(cfg_r[`SRF_IDX_ROBUST]) ==
                           `SRF_DIGIT_ON;
  wire  [4:0] notch_sel;
  assign notch_sel[0] = dig0(cfg_r[`SRF_IDX_FILT_MODE]) ==
                        `SRF_MODE_MANUAL;
  genvar gn;
  generate
    for (gn = 1; gn < 5; gn++) begin : g_notch_en
      assign notch_sel[gn] =
        dig0(cfg_r[`SRF_IDX_N1_SHAPE + 5'(2 * gn)]) ==
        `SRF_DIGIT_ON;
    end
  endgenerate
  wire  [4:0] notch_en   = {notch_sel[4] && !robust_on,
                            notch_sel[3:0]};

  // Shaft filter code: automatic from motor and load, or manual
  wire  [3:0] shaft_sel  = dig0(cfg_r[`SRF_IDX_SHAFT_SEL]);
  // Wide enough that a large inertia ratio saturates, never wraps
  wire [10:0] auto_sum   = 11'(I_MOTOR_SHAFT_CODE) +
                           11'(I_INERTIA_RATIO >> `SRF_INERTIA_SHIFT);
  wire  [4:0] auto_code  = (auto_sum > `SRF_SHAFT_MAX_CODE) ?
                           5'(`SRF_SHAFT_MAX_CODE) :
                           auto_sum[4:0];
  // Other selection digits turn the filter off
  wire  [4:0] shaft_code = (shaft_sel == `SRF_SHAFT_AUTO) ? auto_code :
                           (shaft_sel == `SRF_SHAFT_MANUAL) ?
                           cfg_r[`SRF_IDX_SHAFT_CODE][4:0] :
                           5'h00;
  wire        shaft_code_on = shaft_code >= `SRF_SHAFT_MIN_CODE;
  wire [15:0] shaft_hz   = shaft_code_on ?
                           16'(`SRF_SHAFT_HZ_NUM / 16'(shaft_code)) :
                           16'h0000;
  wire        shaft_en   = shaft_code_on && !notch_en[3];

  // Vibration suppression stages
  wire  [1:0] vs_active  = {gain_vs_ok && vs2_enable &&
                            (vs2_mode != `SRF_MODE_OFF),
                            gain_vs_ok &&
                            (vs1_mode != `SRF_MODE_OFF)};
  // Estimator gives one frequency set per stage, two at most
  wire  [1:0] vs_capture = {vs_active[1] &&
                            (vs2_mode == `SRF_MODE_AUTO) &&
                            I_POS_DONE && est_in_range(I_VS2_EST),
                            vs_active[0] &&
                            (vs1_mode == `SRF_MODE_AUTO) &&
                            I_POS_DONE &&
                            est_in_range(I_VS1_EST)};

  // Software writes first, then tuning hardware overrides them
  always_comb begin
    for (int i = 0; i < `SRF_NREG; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    tune_cnt_nxt[0] = tune_cnt_r[0];
    tune_cnt_nxt[1] = tune_cnt_r[1];
    if (sw_wr) begin
      cfg_nxt[reg_idx] = is_notch_freq(reg_idx) ?
                         clamp_notch(I_PWDATA[15:0]) :
                         I_PWDATA[15:0];
    end
    if (sw_wr && (reg_idx == `SRF_IDX_VS1_MODE)) begin
      tune_cnt_nxt[0] = 8'h00;
    end
    if (sw_wr && (reg_idx == `SRF_IDX_VS2_MODE)) begin
      tune_cnt_nxt[1] = 8'h00;
    end
    if (vs_capture[0]) begin
      cfg_nxt[`SRF_IDX_VS1_BASE]        = I_VS1_EST.vib_freq;
      cfg_nxt[`SRF_IDX_VS1_BASE + 5'h1] = I_VS1_EST.res_freq;
      cfg_nxt[`SRF_IDX_VS1_BASE + 5'h2] = I_VS1_EST.vib_damp;
      cfg_nxt[`SRF_IDX_VS1_BASE + 5'h3] = I_VS1_EST.res_damp;
      tune_cnt_nxt[0] = tune_cnt_r[0] + 8'h01;
      if (tune_cnt_r[0] + 8'h01 >= TUNE_COUNT) begin
        cfg_nxt[`SRF_IDX_VS1_MODE] = {cfg_r[`SRF_IDX_VS1_MODE][15:4],
                                      `SRF_MODE_MANUAL};
        tune_cnt_nxt[0] = 8'h00;
      end
    end
    if (vs_capture[1]) begin
      cfg_nxt[`SRF_IDX_VS2_BASE]        = I_VS2_EST.vib_freq;
      cfg_nxt[`SRF_IDX_VS2_BASE + 5'h1] = I_VS2_EST.res_freq;
      cfg_nxt[`SRF_IDX_VS2_BASE + 5'h2] = I_VS2_EST.vib_damp;
      cfg_nxt[`SRF_IDX_VS2_BASE + 5'h3] = I_VS2_EST.res_damp;
      tune_cnt_nxt[1] = tune_cnt_r[1] + 8'h01;
      if (tune_cnt_r[1] + 8'h01 >= TUNE_COUNT) begin
        cfg_nxt[`SRF_IDX_VS2_MODE] = {cfg_r[`SRF_IDX_VS2_MODE][15:8],
                                      `SRF_MODE_MANUAL,
                                      cfg_r[`SRF_IDX_VS2_MODE][3:0]};
        tune_cnt_nxt[1] = 8'h00;
      end
    end
    cfg_nxt[`SRF_IDX_STATUS] = 16'(stat_r);
  end

  // Reset leaves all zero: shaft auto, robust off
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int i = 0; i < `SRF_NREG; i++) begin
        cfg_r[i] <= 16'h0000;
      end
      tune_cnt_r[0] <= 8'h00;
      tune_cnt_r[1] <= 8'h00;
    end else begin
      cfg_r        <= cfg_nxt;
      tune_cnt_r   <= tune_cnt_nxt;
    end
  end

  assign stat_nxt = '{notch_en: notch_en, shaft_en: shaft_en,
                      vs_active: vs_active};

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      stat_r       <= '0;
      shaft_hz_r   <= 16'h0000;
      shaft_code_r <= 5'h00;
    end else begin
      stat_r       <= stat_nxt;
      shaft_hz_r   <= shaft_hz;
      shaft_code_r <= shaft_code;
    end
  end

  // One wait-free access cycle; pready high in the cycle after setup
  wire [31:0] rd_word = (addr_ok ? 32'(cfg_r[reg_idx]) : 32'h0000_0000);
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      prdata_r  <= (setup && !I_PWRITE) ? rd_word : 32'h0000_0000;
      pslverr_r <= setup && !addr_ok;
    end
  end

  // Filter arithmetic lives elsewhere; each stage is one register
  genvar gp;
  generate
    for (gp = 0; gp < PIPE_DEPTH; gp++) begin : g_pipe
      always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
          pipe_r[gp]   <= '0;
          pipe_v_r[gp] <= 1'b0;
        end else if (gp == 0) begin
          pipe_r[gp]   <= I_SAMPLE;
          pipe_v_r[gp] <= I_SAMPLE_VALID;
        end else begin
          pipe_r[gp]   <= pipe_r[gp-1];
          pipe_v_r[gp] <= pipe_v_r[gp-1];
        end
      end
    end
  endgenerate

  assign O_PREADY       = pready_r;
  assign O_PRDATA       = prdata_r;
  assign O_PSLVERR      = pslverr_r;
  assign O_SAMPLE       = pipe_r[PIPE_DEPTH-1];
  assign O_SAMPLE_VALID = pipe_v_r[PIPE_DEPTH-1];
  assign O_FILT_STAT    = stat_r;
  assign O_SHAFT_HZ     = shaft_hz_r;
  assign O_SHAFT_CODE   = shaft_code_r;

endmodule // srf_filter_select

// [srf_filter_select_props.sv]
// Port-level properties of the resonance filter selection block
`timescale 1ns/100ps
module srf_filter_select_props #(
  parameter int DATA_W     = 16,
  parameter int PIPE_DEPTH = 6
) (
  input wire logic                    I_CLK,
  input wire logic                    I_NRST,
  input wire logic                    I_PSEL,
  input wire logic                    I_PENABLE,
  input wire logic [11:0]             I_PADDR,
  input wire logic                    O_PREADY,
  input wire logic [31:0]             O_PRDATA,
  input wire logic                    O_PSLVERR,
  input wire logic [DATA_W-1:0]       I_SAMPLE,
  input wire logic                    I_SAMPLE_VALID,
  input wire logic [DATA_W-1:0]       O_SAMPLE,
  input wire logic                    O_SAMPLE_VALID,
  input wire srf_pkg::srf_filt_stat_s O_FILT_STAT,
  input wire logic [15:0]             O_SHAFT_HZ,
  input wire logic [4:0]              O_SHAFT_CODE
);
  logic [3:0] up_r;
  logic       bad;
  logic       warm;
  assign bad = (I_PADDR[11:7] != 5'h00) || (I_PADDR[1:0] != 2'h0)
               || (I_PADDR[6:2] > 5'h1a);
  // Pipeline history is stale until refilled after reset
  assign warm = up_r > PIPE_DEPTH;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) up_r <= 4'h0;
    else if (up_r != 4'hf) up_r <= up_r + 4'h1;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  AST_RDY: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("ready missing after setup");
  AST_RDY_ONE: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  AST_PRD_IDLE: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside access");
  AST_PRD_HI: assert property (O_PREADY |-> O_PRDATA[31:16] == 16'h0)
    else $error("upper read data not zero");
  AST_SLVERR: assert property (O_PREADY |-> O_PSLVERR == bad)
    else $error("error flag wrong for address");
  AST_SHAFT_OFF: assert property (O_SHAFT_CODE < 5'h02 |->
    O_SHAFT_HZ == 16'h0 && !O_FILT_STAT.shaft_en)
    else $error("low shaft code not disabled");
  AST_SHAFT_HZ: assert property (O_SHAFT_CODE >= 5'h02 |->
    O_SHAFT_HZ == 16'(16'h2328 / O_SHAFT_CODE))
    else $error("shaft frequency wrong");
  AST_N4_SHAFT: assert property (O_FILT_STAT.notch_en[3] |->
    !O_FILT_STAT.shaft_en)
    else $error("shaft filter on with notch four");
  AST_PIPE_V: assert property (warm |->
    O_SAMPLE_VALID == $past(I_SAMPLE_VALID, PIPE_DEPTH))
    else $error("sample valid delay wrong");
  AST_PIPE_D: assert property (warm && O_SAMPLE_VALID |->
    O_SAMPLE == $past(I_SAMPLE, PIPE_DEPTH))
    else $error("sample data altered");
  cover property (O_PREADY && O_PSLVERR);
  cover property (O_FILT_STAT.notch_en[3]);
  cover property (O_FILT_STAT.vs_active == 2'h3);
endmodule // srf_filter_select_props
bind srf_filter_select srf_filter_select_props #(.DATA_W(DATA_W),
  .PIPE_DEPTH(PIPE_DEPTH)) u_props (.I_CLK(I_CLK), .I_NRST(I_NRST),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR),
  .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR),
  .I_SAMPLE(I_SAMPLE), .I_SAMPLE_VALID(I_SAMPLE_VALID),
  .O_SAMPLE(O_SAMPLE), .O_SAMPLE_VALID(O_SAMPLE_VALID),
  .O_FILT_STAT(O_FILT_STAT), .O_SHAFT_HZ(O_SHAFT_HZ),
  .O_SHAFT_CODE(O_SHAFT_CODE));

// [srf_loop_model.sv]
// Servo loop model: samples, positioning pulses, estimates
`timescale 1ns/100ps
module srf_loop_model (
  input  wire logic            i_clk,
  input  wire logic            i_nrst,
  input  wire logic            i_move,
  input  wire logic [15:0]     i_freq,
  output logic [15:0]          o_sample,
  output logic                 o_valid,
  output logic                 o_pos_done,
  output srf_pkg::srf_vs_est_s o_est
);
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sample <= 16'h0;
      o_valid <= 1'b0;
      o_pos_done <= 1'b0;
    end else begin
      o_sample <= o_sample + 16'h3b1d;
      o_valid <= ~o_valid;
      o_pos_done <= i_move;
    end
  end
  // Two distinct frequencies per estimate, vibration and resonance
  assign o_est = '{valid: 1'b1, vib_freq: i_freq,
    res_freq: i_freq + 16'h0010, vib_damp: 16'h0021, res_damp: 16'h0042};
endmodule // srf_loop_model

// [srf_params.svh]
// Constants for the resonance filter selection block
`ifndef SRF_PARAMS_SVH
`define SRF_PARAMS_SVH
`define SRF_IDX_FILT_MODE  5'h00
`define SRF_IDX_N1_FREQ    5'h01
`define SRF_IDX_N1_SHAPE   5'h02
`define SRF_IDX_N5_SHAPE   5'h0a
`define SRF_IDX_ROBUST     5'h0b
`define SRF_IDX_SHAFT_SEL  5'h0c
`define SRF_IDX_SHAFT_CODE 5'h0d
`define SRF_IDX_GAIN_MODE  5'h0e
`define SRF_IDX_VS1_MODE   5'h0f
`define SRF_IDX_VS2_MODE   5'h10
`define SRF_IDX_VS2_EN     5'h11
`define SRF_IDX_VS1_BASE   5'h12
`define SRF_IDX_VS2_BASE   5'h16
`define SRF_IDX_STATUS     5'h1a
`define SRF_NREG           27
`define SRF_MODE_MANUAL    4'h2
`define SRF_MODE_AUTO      4'h1
`define SRF_MODE_OFF       4'h0
`define SRF_DIGIT_ON       4'h1
`define SRF_GAIN_AUTO2     4'h2
`define SRF_GAIN_MANUAL    4'h3
`define SRF_SHAFT_AUTO     4'h0
`define SRF_SHAFT_MANUAL   4'h1
`define SRF_SHAFT_MIN_CODE 5'h02
`define SRF_SHAFT_MAX_CODE 6'h1f
`define SRF_SHAFT_HZ_NUM   16'h2328
`define SRF_NOTCH_MIN_HZ   16'h000a
`define SRF_NOTCH_MAX_HZ   16'h1194
`define SRF_VS_EST_MIN     16'h000a
`define SRF_VS_EST_MAX     16'h03e8
`define SRF_INERTIA_SHIFT  6
`endif

// [srf_pkg.sv]
// Types shared by the resonance filter selection block
package srf_pkg;
  typedef logic [15:0] srf_word_t;
  typedef struct packed {
    logic      valid;
    srf_word_t vib_freq;
    srf_word_t res_freq;
    srf_word_t vib_damp;
    srf_word_t res_damp;
  } srf_vs_est_s;
  typedef struct packed {
    logic [4:0] notch_en;
    logic       shaft_en;
    logic [1:0] vs_active;
  } srf_filt_stat_s;
endpackage

// [tb.sv]
// Self-checking bench for the resonance filter selection block
`timescale 1ns/100ps
`include "srf_params.svh"
module tb;
  logic                    clk, nrst, psel, pen, pwr, prdy, perr;
  logic                    smpv, osmpv, pdone, mv, e;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prd, q;
  logic [15:0]             smp, osmp, inert, frq, shz;
  logic [15:0]             vs [8];
  logic [4:0]              mcode, scode;
  srf_pkg::srf_vs_est_s    est;
  srf_pkg::srf_filt_stat_s stat;
  int                      seed, fails, samples_checked, cyc, k;
  srf_filter_select #(.TUNE_COUNT(8'h02)) u_dut (.I_CLK(clk),
    .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(prdy), .O_PRDATA(prd),
    .O_PSLVERR(perr), .I_SAMPLE(smp), .I_SAMPLE_VALID(smpv),
    .O_SAMPLE(osmp), .O_SAMPLE_VALID(osmpv), .I_MOTOR_SHAFT_CODE(mcode),
    .I_INERTIA_RATIO(inert), .I_POS_DONE(pdone), .I_VS1_EST(est),
    .I_VS2_EST(est), .O_FILT_STAT(stat), .O_SHAFT_HZ(shz),
    .O_SHAFT_CODE(scode));
  srf_loop_model u_loop (.i_clk(clk), .i_nrst(nrst), .i_move(mv),
    .i_freq(frq), .o_sample(smp), .o_valid(smpv), .o_pos_done(pdone),
    .o_est(est));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [4:0] i, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {5'h00, i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Answer taken at the edge where ready is sampled high
    do @(posedge clk); while (prdy !== 1'b1);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [4:0] i, input logic [31:0] x);
    apb(1'b0, i, 32'h0);
    chk(q, x);
  endtask
  task automatic pulse();
    @(posedge clk);
    mv <= 1'b1;
    @(posedge clk);
    mv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [4:0] exp_auto(logic [4:0] m, logic [15:0] r);
    logic [16:0] s;
    s = 17'(m) + 17'(r >> 6);
    return (s > 17'h1f) ? 5'h1f : s[4:0];
  endfunction
  function automatic logic [15:0] exp_hz(logic [4:0] c);
    return (c < 5'h02) ? 16'h0 : 16'(16'h2328 / c);
  endfunction
  initial begin
    {nrst, psel, pen, pwr, paddr, pwdata, inert, mv} = '0;
    mcode = 5'h05;
    frq = 16'h0005;
    seed = 32'h3976;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(stat, 8'h04);
    rd(`SRF_IDX_ROBUST, 32'h0);
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      mcode <= 5'($random(seed));
      inert <= (k == 0) ? 16'hffff : 16'($random(seed)) >> (k * 2);
      repeat (3) @(posedge clk);
      #1;
      chk(scode, exp_auto(mcode, inert));
      chk(shz, exp_hz(exp_auto(mcode, inert)));
    end
    wr(`SRF_IDX_SHAFT_SEL, 32'h1);
    for (k = 0; k < 32; k++) begin
      wr(`SRF_IDX_SHAFT_CODE, k);
      chk({scode, shz, stat.shaft_en}, {5'(k), exp_hz(k), k > 1});
    end
    wr(`SRF_IDX_FILT_MODE, 32'h1);
    chk(stat.notch_en, 5'h00);
    wr(`SRF_IDX_FILT_MODE, 32'h2);
    chk(stat.notch_en, 5'h01);
    for (k = 1; k < 5; k++) begin
      wr(5'(2 + 2 * k), 32'h1);
      chk({stat.notch_en, stat.shaft_en}, {5'((2 << k) - 1), k < 3});
    end
    wr(`SRF_IDX_ROBUST, 32'h1);
    chk(stat.notch_en, 5'h0f);
    wr(`SRF_IDX_ROBUST, 32'h0);
    for (k = 0; k < 3; k++) begin
      wr(`SRF_IDX_N1_FREQ, k == 0 ? 32'h5 : k == 1 ? 32'hffff : 32'h64);
      rd(`SRF_IDX_N1_FREQ, k == 0 ? 32'ha : k == 1 ? 32'h1194 : 32'h64);
    end
    apb(1'b0, 5'h1b, 32'h0);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    wr(`SRF_IDX_STATUS, 32'hffff);
    rd(`SRF_IDX_STATUS, 32'hf8);
    // Motor held still while vibration parameters are written
    wr(`SRF_IDX_VS1_MODE, 32'h2);
    wr(`SRF_IDX_VS2_EN, 32'h1);
    wr(`SRF_IDX_VS2_MODE, 32'h20);
    for (k = 0; k < 4; k++) begin
      wr(`SRF_IDX_GAIN_MODE, k);
      chk(stat.vs_active, k > 1 ? 2'h3 : 2'h0);
    end
    for (k = 0; k < 8; k++) begin
      vs[k] = 16'($random(seed));
      wr(5'(`SRF_IDX_VS1_BASE + k), {16'($random(seed)), vs[k]});
      rd(5'(`SRF_IDX_VS1_BASE + k), vs[k]);
    end
    wr(`SRF_IDX_VS2_MODE, 32'h0);
    chk(stat.vs_active, 2'h1);
    wr(`SRF_IDX_VS1_MODE, 32'h1);
    pulse();
    rd(`SRF_IDX_VS1_BASE, vs[0]);
    frq <= 16'h012c;
    pulse();
    rd(`SRF_IDX_VS1_MODE, 32'h1);
    pulse();
    rd(`SRF_IDX_VS1_BASE, 32'h12c);
    rd(5'(`SRF_IDX_VS1_BASE + 1), 32'h13c);
    rd(`SRF_IDX_VS1_MODE, 32'h2);
    wrap_up();
  end
endmodule // tb
